// ==== design/timer1_consts.svh ====
// Purpose: offsets, field positions, reset values and delays of timer 1
// Assumes: APB byte address is four times the register index
// Notes: definitions only
`ifndef TIMER1_CONSTS_SVH
`define TIMER1_CONSTS_SVH
`define IDX_COUNT 6'h20
`define IDX_CMP_A 6'h21
`define IDX_CMP_B 6'h22
`define IDX_CMP_TOP 6'h23
`define IDX_FAST_CLK 6'h27
`define IDX_GENERAL 6'h2C
`define IDX_MAIN 6'h30
`define IDX_FLAGS 6'h38
`define IDX_MASK 6'h39
`define MAIN_CLR_TOP 7
`define MAIN_PWM_A 6
`define GEN_SYNC_HOLD 7
`define GEN_PWM_B 6
`define GEN_FORCE_B 3
`define GEN_FORCE_A 2
`define GEN_PRE_RST 1
`define FAST_SEL_BIT 2
`define BIT_CH_A 6
`define BIT_CH_B 5
`define REG_RESET 8'h00
`define MASK_WRITABLE 8'h7E
`define WR_DELAY_SYNC 2'h2
`define WR_DELAY_ASYNC 2'h1
`endif

// ==== design/timer1_pkg.sv ====
// Purpose: types shared by the timer 1 control logic
// Assumes: nothing beyond the constants header
// Notes: output mode codes follow the two-bit field
package timer1_pkg;
  typedef enum logic [1:0] {
    OUT_OFF = 2'b00,
    OUT_TOGGLE = 2'b01,
    OUT_CLEAR = 2'b10,
    OUT_SET = 2'b11
  } out_mode_e;
  typedef struct packed {
    logic level;
    logic oe;
  } pin_s;
endpackage

// ==== design/timer1_prescale_compare_ctrl.sv ====
// Purpose: 8-bit timer 1 with prescaler, three compares, APB registers
// Assumes: fast peripheral clock arrives as a pin, sampled by clk_i
// Notes: each fast clock level must last two clk_i cycles, so at most a quarter of clk_i, to be counted
`timescale 1ns/1ps
`include "timer1_consts.svh"

// Behaviour
// (RULE1) Clock select 0 stops counting; n selects source divided by 2**(n-1).
// (RULE2) Fast clock enable picks fast peripheral clock, else system clock.
// (RULE3) PWM B enable runs PWM from compare B; counter clears after top match.
// (RULE4) Normal mode B match: 00 off, 01 toggle, 10 clear, 11 set.
// (RULE5) Compare output drives its pin only when direction bit is one.
// (RULE6) Force B acts like a match, no flag, new modes used, idle in PWM.
// (RULE7) Force A acts like a match, no flag, idle in PWM A.
// (RULE8) Prescaler reset clears prescaler only, self-clears, reads zero.
// (RULE9) Counter is an 8-bit up counter, readable and writable.
// (RULE10) Counter write lands two cycles later synchronous, one asynchronous.
// (RULE11) Matches come only from counting, never from a software write.
// (RULE12) Compare A match sets flag A after one synchronising cycle.
// (RULE13) Compare B match sets flag B after one synchronising cycle.
// (RULE14) Clear-on-top bit makes a top match clear the counter, any mode.
// (RULE15) Mask bit 6 with global enable turns flag A into an interrupt.
// (RULE16) Mask bit 5 with global enable turns flag B into an interrupt.
// (RULE17) Mask bit 7 is read-only zero.
// (RULE18) Flag A clears on vector acknowledge or written one, after sync.
// (RULE19) Mask bit 0 is read-only zero.
module timer1_prescale_compare_ctrl
  import timer1_pkg::*;
#(
  parameter int PRE_W = 14
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core side
  input wire logic gie_i,
  input wire logic vec_ack_a_i,
  input wire logic vec_ack_b_i,
  output logic irq_o,
  // Clock pin and compare pins
  input wire logic fast_peripheral_clock_i,
  input wire logic dir_a_i,
  input wire logic dir_b_i,
  output logic compare_a_output_o,
  output logic compare_a_output_oe_o,
  output logic compare_b_output_o,
  output logic compare_b_output_oe_o
);

  if (PRE_W < 13) begin : g_chk
    $error("PRE_W too small for a 16384 division");
  end

  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic [PRE_W-1:0] div_mask(input logic [3:0] n);
    div_mask = '0;
    for (int i = 0; i < PRE_W; i++) begin
      div_mask[i] = ((i + 1) < int'(n));
    end
  endfunction

  function automatic logic norm_act(input logic [1:0] m, input logic cur);
    case (m)
      OUT_TOGGLE: norm_act = ~cur;
      OUT_CLEAR: norm_act = 1'b0;
      OUT_SET: norm_act = 1'b1;
      default: norm_act = cur;
    endcase
  endfunction

  // Registers
  logic [7:0] main_q;
  logic [7:4] gen_q;
  logic [7:0] mask_q;
  logic fast_clock_select_enable_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [7:0] cmp_top_q;
  logic [7:0] cnt_q;
  logic [7:0] cw_data_q;
  logic [1:0] cw_cnt_q;
  logic psr_q;
  logic [PRE_W-1:0] pre_q;
  logic clr_pend_q;
  logic [1:0] mt_q;
  logic [1:0] flag_q;
  logic [1:0] fclr_q;
  logic [2:0] fsync_q;
  logic fast_lvl_q;
  logic [1:0] oc_q;
  logic [1:0] oe_q;
  logic irq_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // APB decode
  wire acc = psel_i & penable_i & pready_q;
  wire acc_wr = acc & pwrite_i;
  wire [7:0] wd = pwdata_i[7:0];
  wire h_cnt = hit(paddr_i, `IDX_COUNT);
  wire h_a = hit(paddr_i, `IDX_CMP_A);
  wire h_b = hit(paddr_i, `IDX_CMP_B);
  wire h_top = hit(paddr_i, `IDX_CMP_TOP);
  wire h_fast = hit(paddr_i, `IDX_FAST_CLK);
  wire h_gen = hit(paddr_i, `IDX_GENERAL);
  wire h_main = hit(paddr_i, `IDX_MAIN);
  wire h_flag = hit(paddr_i, `IDX_FLAGS);
  wire h_mask = hit(paddr_i, `IDX_MASK);
  wire h_any = h_cnt | h_a | h_b | h_top | h_fast | h_gen | h_main | h_flag | h_mask;
  wire cnt_wr = acc_wr & h_cnt;
  wire gen_wr = acc_wr & h_gen;

  // Force and prescaler reset bits never stored, so they read zero
  wire [7:0] rd_gen = {gen_q, 4'h0};
  wire [7:0] rd_flag = {1'b0, flag_q[0], flag_q[1], 5'h00};
  wire [7:0] rd_fast = {5'h00, fast_clock_select_enable_q, 2'b00};
  wire [7:0] rd_data =
    ({8{h_cnt}} & cnt_q) | ({8{h_a}} & cmp_a_q) | ({8{h_b}} & cmp_b_q) |
    ({8{h_top}} & cmp_top_q) | ({8{h_fast}} & rd_fast) |
    ({8{h_gen}} & rd_gen) | ({8{h_main}} & main_q) |
    ({8{h_flag}} & rd_flag) | ({8{h_mask}} & mask_q);

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & ~h_any;
      prdata_q <= {24'h000000, rd_data};
    end
  end

  // Control fields
  wire [3:0] cs = main_q[3:0];
  wire pwm_a = main_q[`MAIN_PWM_A];
  wire pwm_b = gen_q[`GEN_PWM_B];
  wire clr_en = main_q[`MAIN_CLR_TOP] | pwm_a | pwm_b;
  wire [1:0] mode_a = main_q[5:4];
  wire [1:0] mode_b = gen_q[5:4];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      main_q <= `REG_RESET;
      gen_q <= 4'h0;
      mask_q <= `REG_RESET;
      fast_clock_select_enable_q <= 1'b0;
      cmp_a_q <= `REG_RESET;
      cmp_b_q <= `REG_RESET;
      cmp_top_q <= `REG_RESET;
    end else if (acc_wr) begin
      if (h_main) main_q <= wd;
      if (h_gen) gen_q <= wd[7:4];
      if (h_mask) mask_q <= wd & `MASK_WRITABLE; // (RULE17) (RULE19)
      if (h_fast) fast_clock_select_enable_q <= wd[`FAST_SEL_BIT]; // (RULE2)
      if (h_a) cmp_a_q <= wd;
      if (h_b) cmp_b_q <= wd;
      if (h_top) cmp_top_q <= wd;
    end
  end

  // Prescaler reset is a one-cycle pulse, never readable
  always_ff @(posedge clk_i) begin
    if (srst_i) psr_q <= 1'b0;
    else psr_q <= gen_wr & wd[`GEN_PRE_RST]; // (RULE8)
  end

  // Fast clock pin: three flops, level moves once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fsync_q <= 3'b000;
      fast_lvl_q <= 1'b0;
    end else begin
      fsync_q <= {fsync_q[1:0], fast_peripheral_clock_i};
      if (fsync_q[1] == fsync_q[2]) fast_lvl_q <= fsync_q[2];
    end
  end
  wire fast_rise = (fsync_q[1] == fsync_q[2]) & fsync_q[2] & ~fast_lvl_q;

  // Source and division select
  wire src_tick = fast_clock_select_enable_q ? fast_rise : 1'b1; // (RULE2)
  wire [PRE_W-1:0] dmask = div_mask(cs);
  wire run = (cs != 4'h0); // (RULE1)
  wire cnt_tick = run & src_tick & ((pre_q & dmask) == dmask); // (RULE1)

  always_ff @(posedge clk_i) begin
    if (srst_i || psr_q) pre_q <= '0; // (RULE8)
    else if (run && src_tick) pre_q <= pre_q + 1'b1;
  end

  // Counter write pipeline, models the synchronisation delay
  wire cw_apply = (cw_cnt_q == 2'h1);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cw_cnt_q <= 2'h0;
      cw_data_q <= `REG_RESET;
    end else if (cnt_wr) begin
      cw_cnt_q <= fast_clock_select_enable_q ? `WR_DELAY_ASYNC : `WR_DELAY_SYNC; // (RULE10)
      cw_data_q <= wd;
    end else if (cw_cnt_q != 2'h0) begin
      cw_cnt_q <= cw_cnt_q - 2'h1;
    end
  end

  // Matches only on a counting step
  wire step = cnt_tick & ~cw_apply & ~clr_pend_q; // (RULE11)
  wire [7:0] cnt_nxt = cnt_q + 8'h01;
  wire match_a = step & (cnt_nxt == cmp_a_q); // (RULE11)
  wire match_b = step & (cnt_nxt == cmp_b_q); // (RULE11)
  wire match_top = step & (cnt_nxt == cmp_top_q); // (RULE11)
  wire at_zero = clr_pend_q | (step & (cnt_nxt == 8'h00));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= `REG_RESET;
      clr_pend_q <= 1'b0;
    end else begin
      clr_pend_q <= match_top & clr_en; // (RULE14) (RULE3)
      if (cw_apply) cnt_q <= cw_data_q; // (RULE10)
      else if (clr_pend_q) cnt_q <= 8'h00; // (RULE14) (RULE3)
      else if (step) cnt_q <= cnt_nxt; // (RULE9)
    end
  end

  // Flags: match passes one sync stage, then sets; set beats clear
  wire [1:0] ack = {vec_ack_b_i, vec_ack_a_i};
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mt_q <= 2'b00;
      fclr_q <= 2'b00;
      flag_q <= 2'b00;
    end else begin
      mt_q <= {match_b, match_a};
      fclr_q <= {2{acc_wr & h_flag}} & {wd[`BIT_CH_B], wd[`BIT_CH_A]}; // (RULE18)
      flag_q <= mt_q | (flag_q & ~(fclr_q | ack)); // (RULE12) (RULE13) (RULE18)
    end
  end

  wire [1:0] ien = {mask_q[`BIT_CH_B], mask_q[`BIT_CH_A]};
  always_ff @(posedge clk_i) begin
    if (srst_i) irq_q <= 1'b0;
    else irq_q <= gie_i & |(flag_q & ien); // (RULE15) (RULE16)
  end

  // Output channels; B force may use modes written in the same access
  wire force_b = gen_wr & wd[`GEN_FORCE_B] & ~wd[`GEN_PWM_B]; // (RULE6)
  wire force_a = gen_wr & wd[`GEN_FORCE_A] & ~pwm_a; // (RULE7)
  wire [1:0] ch_match = {match_b, match_a};
  wire [1:0] ch_force = {force_b, force_a};
  wire [1:0] ch_pwm = {pwm_b, pwm_a};
  wire [1:0] ch_dir = {dir_b_i, dir_a_i};
  wire [1:0] ch_mode [2];
  wire [1:0] ch_fmode [2];
  assign ch_mode[0] = mode_a;
  assign ch_mode[1] = mode_b;
  assign ch_fmode[0] = mode_a;
  assign ch_fmode[1] = force_b ? wd[5:4] : mode_b; // (RULE6)

  pin_s pin [2];
  for (genvar i = 0; i < 2; i++) begin : g_ch
    wire pwm_lvl_match = (ch_mode[i] == OUT_SET);
    wire pwm_on = ch_pwm[i] & (ch_mode[i] != OUT_OFF);
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        oc_q[i] <= 1'b0;
        oe_q[i] <= 1'b0;
      end else begin
        oe_q[i] <= ch_dir[i] & (ch_fmode[i] != OUT_OFF); // (RULE5)
        if (pwm_on && ch_match[i]) oc_q[i] <= pwm_lvl_match; // (RULE3)
        else if (pwm_on && at_zero) oc_q[i] <= ~pwm_lvl_match; // (RULE3)
        else if (!ch_pwm[i] && (ch_match[i] || ch_force[i]))
          oc_q[i] <= norm_act(ch_fmode[i], oc_q[i]); // (RULE4) (RULE6) (RULE7)
      end
    end
    assign pin[i] = '{level: oc_q[i], oe: oe_q[i]};
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign irq_o = irq_q;
  assign compare_a_output_o = pin[0].level;
  assign compare_a_output_oe_o = pin[0].oe;
  assign compare_b_output_o = pin[1].level;
  assign compare_b_output_oe_o = pin[1].oe;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_cnt_wr_sync;
    cnt_wr && !fast_clock_select_enable_q;
  endsequence
  sequence s_quiet;
    !cnt_wr && cw_cnt_q == 2'h0 && !clr_pend_q;
  endsequence

  stop_hold_a: assert property ( // (RULE1)
    s_quiet and (cs == 4'h0) |=> cnt_q == $past(cnt_q))
    else $error("counter moved while stopped");

  div_one_a: assert property ( // (RULE2)
    s_quiet and (cs == 4'h1 && !fast_clock_select_enable_q) |=> cnt_q == $past(cnt_nxt))
    else $error("undivided system clock did not count");

  wr_sync_a: assert property ( // (RULE10)
    s_cnt_wr_sync ##1 !cnt_wr |-> ##2 cnt_q == $past(wd, 3))
    else $error("synchronous counter write not landed after two cycles");

  top_clear_a: assert property ( // (RULE14)
    match_top && clr_en && cw_cnt_q == 2'h0 && !cnt_wr |-> ##2 cnt_q == 8'h00)
    else $error("top match did not clear counter");

  write_match_a: assert property ( // (RULE11)
    cw_apply |-> !match_a && !match_b && !match_top)
    else $error("match raised by a counter write");

  cmp_hit_a: assert property ( // (RULE11)
    match_a |=> cnt_q == $past(cmp_a_q))
    else $error("compare A match without counting to its value");

  norm_clear_a: assert property ( // (RULE4)
    match_b && !pwm_b && mode_b == OUT_CLEAR && !gen_wr |=> !oc_q[1])
    else $error("clear mode did not clear output B");

  force_pwm_a: assert property ( // (RULE6)
    gen_wr && wd[`GEN_PWM_B] && !match_b && !at_zero |=> oc_q[1] == $past(oc_q[1]))
    else $error("force B acted in PWM mode");

  flag_a_set_a: assert property ( // (RULE12)
    match_a |-> ##2 flag_q[0])
    else $error("flag A not set two cycles after match");

  flag_b_set_a: assert property ( // (RULE13)
    match_b |-> ##2 flag_q[1])
    else $error("flag B not set two cycles after match");

  flag_ack_a: assert property ( // (RULE18)
    vec_ack_a_i && !mt_q[0] |=> !flag_q[0])
    else $error("flag A survived acknowledge");

  irq_a_a: assert property ( // (RULE15)
    flag_q[0] && mask_q[`BIT_CH_A] && gie_i |=> irq_q)
    else $error("interrupt A not raised");

  irq_b_a: assert property ( // (RULE16)
    !gie_i |=> !irq_q)
    else $error("interrupt raised without global enable");

  mask_rsv_a: assert property ( // (RULE17)
    !mask_q[7] && !mask_q[0])
    else $error("reserved mask bit set");

  psr_clear_a: assert property ( // (RULE8)
    psr_q |=> !psr_q && pre_q == '0)
    else $error("prescaler reset failed");

  pin_gate_a: assert property ( // (RULE5)
    !dir_b_i |=> !compare_b_output_oe_o)
    else $error("output B enabled without direction bit");

endmodule

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the timer 1 control logic
// Assumes: APB slave answers by pready, counter runs from clk_i
// Notes: counts are judged by cycle spans, so prescaler phase is tolerated
`timescale 1ns/1ps
`include "timer1_consts.svh"
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic gie_i = 0, ack_a = 0, ack_b = 0, fast_i = 0, dir_a = 0, dir_b = 0;
  logic fast_run = 0, pready_o, pslverr_o, irq_o, rerr, pa, ea, pb, eb;
  logic [1:0] fdiv = 0;
  logic [7:0] paddr_i = 0, rdat;
  logic [31:0] pwdata_i = 0, prdata_o;
  int errors = 0, samples_checked = 0, cycles = 0;

  timer1_prescale_compare_ctrl #(.PRE_W(14)) i_dut (.clk_i(clk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .gie_i(gie_i), .vec_ack_a_i(ack_a), .vec_ack_b_i(ack_b), .irq_o(irq_o),
    .fast_peripheral_clock_i(fast_i), .dir_a_i(dir_a), .dir_b_i(dir_b),
    .compare_a_output_o(pa), .compare_a_output_oe_o(ea),
    .compare_b_output_o(pb), .compare_b_output_oe_o(eb));

  always #20 clk_i = ~clk_i;
  // Fast pin at a quarter of clk_i, the fastest rate the synchroniser still counts
  always @(posedge clk_i) begin
    fdiv <= fdiv + 2'h1;
    if (fast_run && fdiv[0]) fast_i <= ~fast_i;
  end
  always @(posedge clk_i) begin
    // Updated after the edge so tasks always see the count of edges already passed
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Starts one edge late so a release and a new setup never share a step
  task automatic apb(input logic w, input logic [5:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= {ix, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready_o)
    rdat = prdata_o[7:0];
    rerr = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d);
  endtask
  task automatic rd(input logic [5:0] ix);
    apb(1'b0, ix, 8'h00);
  endtask

  task automatic t_regs;
    rd(`IDX_GENERAL);
    `CHK("general reset", 8'h00, rdat)
    wr(`IDX_MASK, 8'hFF);
    rd(`IDX_MASK);
    `CHK("mask bits", 8'h7E, rdat)
    rd(6'h01);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 8'h00, rdat)
    wr(`IDX_MASK, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_rate;
    logic [7:0] a;
    int d, cd, dv;
    wr(`IDX_COUNT, 8'h55);
    rd(`IDX_COUNT);
    `CHK("count rw", 8'h55, rdat)
    wr(`IDX_GENERAL, 8'h02);
    rd(`IDX_GENERAL);
    `CHK("psr reads 0", 8'h00, rdat)
    rd(`IDX_COUNT);
    `CHK("psr keeps count", 8'h55, rdat)
    for (int s = 0; s < 5; s++) begin
      dv = (s == 0) ? 0 : 1 << (s - 1);
      wr(`IDX_MAIN, 8'(s));
      rd(`IDX_COUNT);
      a = rdat;
      cd = cycles;
      cyc(64);
      rd(`IDX_COUNT);
      d = 8'(rdat - a);
      cd = cycles - cd;
      if (s == 0) `CHK("stopped", a, rdat)
      else `CHK("rate", 1'b1, d * dv > cd - dv && d * dv < cd + dv)
    end
    wr(`IDX_MAIN, 8'h00);
    $display("test rate done");
  endtask

  task automatic t_async;
    logic [7:0] a;
    wr(`IDX_FAST_CLK, 8'h04);
    wr(`IDX_MAIN, 8'h01);
    rd(`IDX_COUNT);
    a = rdat;
    cyc(40);
    rd(`IDX_COUNT);
    `CHK("async idle", a, rdat)
    fast_run <= 1;
    cyc(40);
    rd(`IDX_COUNT);
    `CHK("async runs", 1'b1, rdat != a)
    fast_run <= 0;
    wr(`IDX_MAIN, 8'h00);
    wr(`IDX_FAST_CLK, 8'h00);
    $display("test async done");
  endtask

  task automatic t_irq(input logic [5:0] cix, input logic [7:0] m);
    wr(`IDX_FLAGS, 8'hFF);
    wr(cix, 8'h30);
    wr(`IDX_COUNT, 8'h30);
    cyc(4);
    rd(`IDX_FLAGS);
    `CHK("write no match", 8'h00, rdat & m)
    wr(`IDX_GENERAL, {2'b00, m[5], m[5], m[5], 3'h0});
    wr(`IDX_GENERAL, {2'b00, m[5], 5'h00});
    for (int j = 0; j < 2; j++) begin
      wr(`IDX_MASK, 8'h00);
      wr(`IDX_COUNT, 8'h00);
      wr(`IDX_MAIN, 8'h01);
      cyc(60);
      wr(`IDX_MAIN, 8'h00);
      rd(`IDX_FLAGS);
      `CHK("flag set", m, rdat & m)
      `CHK("irq masked", 1'b0, irq_o)
      wr(`IDX_MASK, m);
      cyc(3);
      `CHK("irq on", 1'b1, irq_o)
      if (j == 0) begin
        gie_i <= 0;
        cyc(3);
        `CHK("irq gie off", 1'b0, irq_o)
        gie_i <= 1;
        ack_a <= m[6];
        ack_b <= m[5];
        @(posedge clk_i);
        ack_a <= 0;
        ack_b <= 0;
      end else wr(`IDX_FLAGS, m);
      cyc(3);
      `CHK("irq cleared", 1'b0, irq_o)
    end
    `CHK("match clears b", 1'b0, pb)
    $display("test irq done");
  endtask

  task automatic t_force;
    logic [1:0] md[5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
    logic ex[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    wr(`IDX_FLAGS, 8'hFF);
    dir_a <= 1;
    dir_b <= 1;
    for (int k = 0; k < 5; k++) begin
      wr(`IDX_GENERAL, {2'b00, md[k], 4'h8});
      wr(`IDX_MAIN, {2'b00, md[k], 4'h0});
      wr(`IDX_GENERAL, {2'b00, md[k], 4'h4});
      cyc(2);
      `CHK("oe b", md[k] != 2'h0, eb)
      `CHK("oe a", md[k] != 2'h0, ea)
      if (md[k] != 2'h0) `CHK("pin b", ex[k], pb)
      if (md[k] != 2'h0) `CHK("pin a", ex[k], pa)
      rd(`IDX_GENERAL);
      `CHK("force reads 0", {2'b00, md[k], 4'h0}, rdat)
    end
    rd(`IDX_FLAGS);
    `CHK("force no flag", 8'h00, rdat & 8'h60)
    wr(`IDX_GENERAL, 8'h28);
    wr(`IDX_MAIN, 8'h70);
    wr(`IDX_GENERAL, 8'h7C);
    cyc(2);
    `CHK("pwm b no force", 1'b0, pb)
    `CHK("pwm a no force", 1'b0, pa)
    dir_b <= 0;
    cyc(3);
    `CHK("dir off", 1'b0, eb)
    wr(`IDX_GENERAL, 8'h00);
    wr(`IDX_MAIN, 8'h00);
    $display("test force done");
  endtask

  task automatic t_top;
    wr(`IDX_CMP_TOP, 8'h05);
    for (int k = 0; k < 2; k++) begin
      wr(`IDX_COUNT, 8'h00);
      wr(`IDX_GENERAL, k ? 8'h40 : 8'h00);
      wr(`IDX_MAIN, k ? 8'h01 : 8'h81);
      repeat (6) begin
        rd(`IDX_COUNT);
        `CHK("top wrap", 1'b1, rdat <= 8'h05)
      end
      wr(`IDX_MAIN, 8'h00);
    end
    wr(`IDX_GENERAL, 8'h00);
    $display("test top done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 0;
    gie_i <= 1;
    t_regs();
    t_rate();
    t_async();
    t_irq(`IDX_CMP_A, 8'h40);
    t_irq(`IDX_CMP_B, 8'h20);
    t_force();
    t_top();
    tally_and_finish();
  end
endmodule
